// ===== logic/cmie_regs.vh
`ifndef CMIE_REGS_VH
`define CMIE_REGS_VH
// mode encodings (one-hot)
`define CMIE_MODE_RUN 4'h1
`define CMIE_MODE_HALT 4'h2
`define CMIE_MODE_WAIT 4'h4
`define CMIE_MODE_STOP 4'h8
// debug command codes
`define CMIE_CMD_MEM 3'h0
`define CMIE_CMD_MEM_STAT 3'h1
`define CMIE_CMD_DBG_REG 3'h2
`define CMIE_CMD_HALT_REQ 3'h3
`define CMIE_CMD_CORE_REG 3'h4
`define CMIE_CMD_STEP 3'h5
`define CMIE_CMD_RESUME 3'h6
// command status codes
`define CMIE_STAT_OK 2'h0
`define CMIE_STAT_LOWPWR 2'h1
`define CMIE_STAT_REFUSED 2'h2
// interrupt sources
`define CMIE_NUM_SRC 8
`define CMIE_EXT_IRQ_BIT 0
// condition code register mask bit position
`define CMIE_CCR_MASK_BIT 3
`define CMIE_CCR_RESET 8'h08
// vector table top, one word per source
`define CMIE_VEC_TOP 16'hfffe
`endif

// ===== logic/cmie_ext_irq.v
`timescale 1ns/100ps
`include "cmie_regs.vh"
module cmie_ext_irq (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_irq_pin_n,
    input wire i_irq_edge_level_select,
    input wire i_clear,
    output reg o_ext_irq_flag
);
    reg sync1;
    reg sync2;
    reg prev;
    wire asserted;
    wire edge_seen;

    assign asserted = sync2;
    assign edge_seen = sync2 & ~prev;

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
            o_ext_irq_flag <= 1'b0;
        end else begin
            sync1 <= ~i_irq_pin_n;
            sync2 <= sync1;
            prev <= sync2;
            // set wins over clear; held while pin asserted only when i_irq_edge_level_select is set
            if (edge_seen) begin
                o_ext_irq_flag <= 1'b1;
            end else if (i_irq_edge_level_select && asserted) begin
                o_ext_irq_flag <= 1'b1;
            end else if (i_clear) begin
                o_ext_irq_flag <= 1'b0;
            end
        end
    end
endmodule

// ===== logic/cmie_core_ctrl.v
// What this block does
// - debug halt suspends program, awaits serial commands
// - non-intrusive commands accepted in run and halt
// - core register, step, resume only in halt
// - resume command returns to running the program
// - wait instruction stops the core clock
// - entering wait clears the global mask
// - interrupt ends wait, starts context stacking
// - wait accepts only halt request, status access
// - status access in low power returns error
// - halt request in wait enters debug halt
// - stop with option set halts all clocks
// - irq flag sets on asserting edge
// - flag held set while pin asserted, in level mode only
// - flags per source, gated by local enable
// - finish instruction before interrupt sequence
// - push pc low, high, index, acc, ccr
// - fetch highest-priority vector, enter routine
// - vector high byte low address, low byte next
`timescale 1ns/100ps
`include "cmie_regs.vh"
module cmie_core_ctrl (
    input wire i_core_clk,
    input wire i_rst,
    // debug command from serial front end
    input wire i_cmd_valid,
    input wire [2:0] i_cmd,
    output reg o_cmd_accept,
    output reg o_cmd_done,
    output reg [1:0] o_cmd_status,
    // core instruction side
    input wire i_instr_done,
    input wire i_wait_exec,
    input wire i_stop_exec,
    input wire i_stop_enable_option,
    input wire i_stop_deep_select,
    input wire [7:0] i_pc_low_byte,
    input wire [7:0] i_pc_high_byte,
    input wire [7:0] i_index_reg,
    input wire [7:0] i_accum,
    input wire [7:0] i_condition_code_reg,
    // interrupt sources
    input wire i_irq_pin_n,
    input wire i_irq_edge_level_select,
    input wire i_ext_irq_clear,
    input wire [`CMIE_NUM_SRC-1:1] i_src_flag,
    input wire [`CMIE_NUM_SRC-1:0] i_src_enable,
    // stack and vector memory
    output reg o_mem_we,
    output reg o_mem_re,
    output reg [15:0] o_mem_addr,
    output reg [7:0] o_mem_wdata,
    input wire [7:0] i_mem_rdata,
    // status out
    output reg [3:0] o_mode,
    output reg o_core_run,
    output reg o_core_clk_en,
    output reg o_sys_clk_en,
    output reg o_stop_deep,
    output reg o_global_mask,
    output reg o_pc_load,
    output reg [15:0] o_pc_value,
    output wire o_ext_irq_flag,
    output wire o_irq_pending
);
    localparam S_IDLE = 4'h1;
    localparam S_PUSH = 4'h2;
    localparam S_VECH = 4'h4;
    localparam S_VECL = 4'h8;

    reg [3:0] seq;
    reg [2:0] push_idx;
    reg [7:0] sp;
    reg [7:0] stack_data [0:4];
    reg [7:0] vec_hi;
    reg [2:0] win_src;
    wire [`CMIE_NUM_SRC-1:0] flags;
    wire [`CMIE_NUM_SRC-1:0] req;
    wire [2:0] top_src;
    wire any_req;
    wire cmd_ok;
    integer k;

    ////////////////////////////////////////////////////////////////////
    // command class helpers
    function cmd_nonintr;
        input [2:0] c;
        begin
            cmd_nonintr = (c == `CMIE_CMD_MEM) || (c == `CMIE_CMD_MEM_STAT) ||
                (c == `CMIE_CMD_DBG_REG) || (c == `CMIE_CMD_HALT_REQ);
        end
    endfunction

    function cmd_lowpwr_ok;
        input [2:0] c;
        begin
            cmd_lowpwr_ok = (c == `CMIE_CMD_HALT_REQ) ||
                (c == `CMIE_CMD_MEM_STAT);
        end
    endfunction

    // highest index wins: higher sources sit lower in the table
    function [2:0] pick_top;
        input [`CMIE_NUM_SRC-1:0] r;
        integer i;
        begin
            pick_top = 3'h0;
            for (i = 0; i < `CMIE_NUM_SRC; i = i + 1) begin
                if (r[i]) begin
                    pick_top = i[2:0];
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    cmie_ext_irq u_ext_irq (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_irq_pin_n(i_irq_pin_n),
        .i_irq_edge_level_select(i_irq_edge_level_select),
        .i_clear(i_ext_irq_clear),
        .o_ext_irq_flag(o_ext_irq_flag)
    );

    assign flags = {i_src_flag, o_ext_irq_flag};
    genvar g;
    generate
        for (g = 0; g < `CMIE_NUM_SRC; g = g + 1) begin : gate
            assign req[g] = flags[g] & i_src_enable[g];
        end
    endgenerate
    assign any_req = |req;
    assign o_irq_pending = any_req;
    assign top_src = pick_top(req);

    ////////////////////////////////////////////////////////////////////
    // command legality per mode
    assign cmd_ok = (o_mode == `CMIE_MODE_HALT) ? 1'b1 :
        (o_mode == `CMIE_MODE_RUN) ? cmd_nonintr(i_cmd) :
        cmd_lowpwr_ok(i_cmd);

    always @* begin
        o_cmd_accept = i_cmd_valid && cmd_ok;
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_cmd_done <= 1'b0;
            o_cmd_status <= `CMIE_STAT_OK;
        end else begin
            o_cmd_done <= i_cmd_valid;
            if (!i_cmd_valid) begin
                o_cmd_status <= `CMIE_STAT_OK;
            end else if (!cmd_ok) begin
                o_cmd_status <= `CMIE_STAT_REFUSED;
            end else if (i_cmd == `CMIE_CMD_MEM_STAT &&
                         (o_mode == `CMIE_MODE_WAIT ||
                          o_mode == `CMIE_MODE_STOP)) begin
                o_cmd_status <= `CMIE_STAT_LOWPWR;
            end else begin
                o_cmd_status <= `CMIE_STAT_OK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode and interrupt sequencer
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_mode <= `CMIE_MODE_RUN;
            seq <= S_IDLE;
            push_idx <= 3'h0;
            sp <= 8'hff;
            vec_hi <= 8'h00;
            win_src <= 3'h0;
            o_global_mask <= 1'b1;
            o_stop_deep <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_re <= 1'b0;
            o_mem_addr <= 16'h0000;
            o_mem_wdata <= 8'h00;
            o_pc_load <= 1'b0;
            o_pc_value <= 16'h0000;
            for (k = 0; k < 5; k = k + 1) begin
                stack_data[k] <= 8'h00;
            end
        end else begin
            o_mem_we <= 1'b0;
            o_mem_re <= 1'b0;
            o_pc_load <= 1'b0;
            case (o_mode)
            `CMIE_MODE_RUN: begin
                if (i_cmd_valid && i_cmd == `CMIE_CMD_HALT_REQ) begin
                    o_mode <= `CMIE_MODE_HALT;
                end else if (seq == S_IDLE && i_instr_done) begin
                    if (any_req && !o_global_mask) begin
                        seq <= S_PUSH;
                        push_idx <= 3'h0;
                        win_src <= top_src;
                        stack_data[0] <= i_pc_low_byte;
                        stack_data[1] <= i_pc_high_byte;
                        stack_data[2] <= i_index_reg;
                        stack_data[3] <= i_accum;
                        stack_data[4] <= i_condition_code_reg;
                    end else if (i_wait_exec) begin
                        o_mode <= `CMIE_MODE_WAIT;
                        o_global_mask <= 1'b0;
                    end else if (i_stop_exec && i_stop_enable_option) begin
                        o_mode <= `CMIE_MODE_STOP;
                        o_stop_deep <= i_stop_deep_select;
                    end
                end
            end
            `CMIE_MODE_HALT: begin
                if (i_cmd_valid && i_cmd == `CMIE_CMD_RESUME) begin
                    o_mode <= `CMIE_MODE_RUN;
                end
            end
            `CMIE_MODE_WAIT: begin
                if (i_cmd_valid && i_cmd == `CMIE_CMD_HALT_REQ) begin
                    o_mode <= `CMIE_MODE_HALT;
                end else if (any_req) begin
                    o_mode <= `CMIE_MODE_RUN;
                    seq <= S_PUSH;
                    push_idx <= 3'h0;
                    win_src <= top_src;
                    stack_data[0] <= i_pc_low_byte;
                    stack_data[1] <= i_pc_high_byte;
                    stack_data[2] <= i_index_reg;
                    stack_data[3] <= i_accum;
                    stack_data[4] <= i_condition_code_reg;
                end
            end
            `CMIE_MODE_STOP: begin
                // any enabled pending flag wakes stop straight back to run, with no stacking
                if (any_req) begin
                    o_mode <= `CMIE_MODE_RUN;
                    o_stop_deep <= 1'b0;
                end
            end
            default: begin
                o_mode <= `CMIE_MODE_RUN;
            end
            endcase

            // stacking and vector fetch run only in run mode
            if (o_mode == `CMIE_MODE_RUN) begin
                case (seq)
                S_IDLE: begin
                end
                S_PUSH: begin
                    o_mem_we <= 1'b1;
                    o_mem_addr <= {8'h01, sp};
                    o_mem_wdata <= stack_data[push_idx];
                    sp <= sp - 8'h01;
                    if (push_idx == 3'h4) begin
                        o_global_mask <= 1'b1;
                        seq <= S_VECH;
                    end else begin
                        push_idx <= push_idx + 3'h1;
                    end
                end
                S_VECH: begin
                    o_mem_re <= 1'b1;
                    o_mem_addr <= `CMIE_VEC_TOP - {12'h000, win_src, 1'b0};
                    seq <= S_VECL;
                end
                // read data trails its strobe by one cycle
                S_VECL: begin
                    if (!o_mem_addr[0]) begin
                        o_mem_re <= 1'b1;
                        o_mem_addr <= o_mem_addr + 16'h0001;
                    end else if (o_mem_re) begin
                        vec_hi <= i_mem_rdata;
                    end else begin
                        o_pc_value <= {vec_hi, i_mem_rdata};
                        o_pc_load <= 1'b1;
                        seq <= S_IDLE;
                    end
                end
                default: begin
                    seq <= S_IDLE;
                end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clock gating, halted program in debug, no clocks in stop
    always @* begin
        o_core_run = (o_mode == `CMIE_MODE_RUN) && (seq == S_IDLE);
        o_core_clk_en = (o_mode == `CMIE_MODE_RUN);
        o_sys_clk_en = (o_mode != `CMIE_MODE_STOP);
    end
endmodule

// ===== tb/cmie_dbg_host.sv
`timescale 1ns/100ps
module cmie_dbg_host (
    input wire i_core_clk,
    output reg o_cmd_valid,
    output reg [2:0] o_cmd
);
    // idle code is junk on purpose, never a stale command
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = 3'h7;
    end
    // one command per pulse; mode choice is left to the bench
    task send(input [2:0] c);
        begin
            @(negedge i_core_clk);
            o_cmd_valid = 1'b1;
            o_cmd = c;
            @(negedge i_core_clk);
            o_cmd_valid = 1'b0;
            o_cmd = ~c;
        end
    endtask
endmodule

// ===== tb/cmie_assertions.sv
`timescale 1ns/100ps
`include "cmie_regs.vh"
module cmie_assertions (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_cmd_valid,
    input wire [2:0] i_cmd,
    input wire o_cmd_accept,
    input wire [1:0] o_cmd_status,
    input wire i_instr_done,
    input wire i_irq_pin_n,
    input wire i_irq_edge_level_select,
    input wire [7:1] i_src_flag,
    input wire [7:0] i_src_enable,
    input wire o_mem_we,
    input wire o_mem_re,
    input wire [15:0] o_mem_addr,
    input wire [3:0] o_mode,
    input wire o_core_run,
    input wire o_core_clk_en,
    input wire o_global_mask,
    input wire o_pc_load,
    input wire o_ext_irq_flag,
    input wire o_irq_pending
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire run = o_mode == `CMIE_MODE_RUN;
    wire halt = o_mode == `CMIE_MODE_HALT;
    wire lowpwr = o_mode == `CMIE_MODE_WAIT || o_mode == `CMIE_MODE_STOP;
    wire is_cmd_halt = i_cmd_valid && i_cmd == `CMIE_CMD_HALT_REQ;
    wire is_resume = i_cmd_valid && i_cmd == `CMIE_CMD_RESUME;
    sequence s_start;
        i_instr_done && run && o_irq_pending && !o_global_mask && !o_mem_we
            && !o_mem_re && !o_pc_load && !i_cmd_valid;
    endsequence
    sequence s_vector;
        o_global_mask && o_mem_re && !o_mem_addr[0]
            ##1 o_mem_re && o_mem_addr[0] ##2 o_pc_load;
    endsequence
    a_halt_req_halts:
        assert property (is_cmd_halt && o_mode != `CMIE_MODE_STOP |=> halt)
            else $error("no halt");
    a_refused_status:
        assert property (i_cmd_valid && !o_cmd_accept
            |=> o_cmd_status == `CMIE_STAT_REFUSED) else $error("accept off");
    a_halt_stops_cpu:
        assert property (halt |-> !o_core_run) else $error("runs in halt");
    a_halt_only_cmds:
        assert property (i_cmd_valid && i_cmd >= `CMIE_CMD_CORE_REG && !halt
            |=> o_cmd_status == `CMIE_STAT_REFUSED) else $error("not refused");
    a_resume_runs:
        assert property (is_resume && halt |=> run) else $error("no resume");
    a_wait_no_clock:
        assert property (o_mode == `CMIE_MODE_WAIT |-> !o_core_clk_en)
            else $error("clock on in wait");
    a_wait_unmasks:
        assert property ($rose(o_mode == `CMIE_MODE_WAIT) |-> !o_global_mask)
            else $error("mask set in wait");
    a_lowpwr_status:
        assert property (i_cmd_valid && i_cmd == `CMIE_CMD_MEM_STAT && lowpwr
            |=> o_cmd_status == `CMIE_STAT_LOWPWR) else $error("bad status");
    a_ext_flag_held:
        assert property (o_ext_irq_flag && i_irq_edge_level_select
            && !i_irq_pin_n && !$past(i_irq_pin_n) && !$past(i_irq_pin_n, 2)
            |=> o_ext_irq_flag) else $error("flag dropped");
    a_pending_gate:
        assert property (o_irq_pending
            == |({i_src_flag, o_ext_irq_flag} & i_src_enable))
            else $error("bad pending");
    a_stack_then_vec:
        assert property (s_start |=> !o_mem_we ##1 o_mem_we [*5] ##1 s_vector)
            else $error("bad entry");
endmodule
bind cmie_core_ctrl cmie_assertions chk (.*);

// ===== tb/tb_cpu_mode_and_interrupt_entry.sv
`timescale 1ns/100ps
`include "cmie_regs.vh"
module tb_cpu_mode_and_interrupt_entry;
    reg i_core_clk, i_rst, i_instr_done, i_wait_exec, i_stop_exec;
    reg i_stop_enable_option, i_stop_deep_select, i_irq_pin_n;
    reg i_irq_edge_level_select, i_ext_irq_clear;
    reg [7:1] i_src_flag;
    reg [7:0] i_src_enable, i_mem_rdata, i_pc_low_byte, i_pc_high_byte;
    reg [7:0] i_index_reg, i_accum, i_condition_code_reg;
    wire i_cmd_valid, o_cmd_done, o_mem_we, o_mem_re, o_core_run;
    wire o_core_clk_en, o_sys_clk_en, o_stop_deep, o_global_mask, o_pc_load;
    wire o_ext_irq_flag, o_irq_pending, o_cmd_accept;
    wire [2:0] i_cmd;
    wire [1:0] o_cmd_status;
    wire [15:0] o_mem_addr, o_pc_value;
    wire [7:0] o_mem_wdata;
    wire [3:0] o_mode;
    wire [39:0] ctx = {i_condition_code_reg, i_accum, i_index_reg,
        i_pc_high_byte, i_pc_low_byte};
    integer fail_count, compares, cyc, i;
    cmie_core_ctrl DUT (.*);
    cmie_dbg_host host (.i_core_clk(i_core_clk), .o_cmd_valid(i_cmd_valid),
        .o_cmd(i_cmd));
    always #20 i_core_clk = ~i_core_clk;
    // memory answers addr-derived bytes so a swapped fetch shows up
    always @(posedge i_core_clk) begin
        i_mem_rdata <= o_mem_addr[7:0] ^ 8'h3c;
        cyc = cyc + 1;
        if (cyc == 3000) begin
            fail_count = fail_count + 1;
            final_report;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task final_report;
        begin
            $display("compares %0d fail_count %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input string nm, input [15:0] exp, input [15:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task tick;
        @(negedge i_core_clk);
    endtask
    task cmd(input [2:0] c, input [1:0] st);
        begin
            host.send(c);
            chk("done", 1, o_cmd_done);
            chk("status", st, o_cmd_status);
        end
    endtask
    task instr(input w, input s);
        begin
            {i_wait_exec, i_stop_exec, i_instr_done} = {w, s, 1'b1};
            tick;
            {i_wait_exec, i_stop_exec, i_instr_done} = 3'h0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_debug;
        begin
            for (i = 0; i < 3; i = i + 1) cmd(i, `CMIE_STAT_OK);
            for (i = 4; i < 7; i = i + 1) cmd(i, `CMIE_STAT_REFUSED);
            chk("mode", `CMIE_MODE_RUN, o_mode);
            cmd(`CMIE_CMD_HALT_REQ, `CMIE_STAT_OK);
            chk("mode", `CMIE_MODE_HALT, o_mode);
            chk("run", 0, o_core_run);
            for (i = 0; i < 3; i = i + 1) cmd(i, `CMIE_STAT_OK);
            cmd(`CMIE_CMD_CORE_REG, `CMIE_STAT_OK);
            cmd(`CMIE_CMD_RESUME, `CMIE_STAT_OK);
            chk("mode", `CMIE_MODE_RUN, o_mode);
            $display("debug commands test ended");
        end
    endtask
    task t_wait_halt;
        begin
            instr(1, 0);
            chk("mode", `CMIE_MODE_WAIT, o_mode);
            chk("clk_en", 0, o_core_clk_en);
            chk("mask", 0, o_global_mask);
            cmd(`CMIE_CMD_MEM_STAT, `CMIE_STAT_LOWPWR);
            cmd(`CMIE_CMD_HALT_REQ, `CMIE_STAT_OK);
            chk("mode", `CMIE_MODE_HALT, o_mode);
            cmd(`CMIE_CMD_RESUME, `CMIE_STAT_OK);
            $display("wait and halt test ended");
        end
    endtask
    // flag 7 set but disabled, so source 5 must beat source 2
    task t_irq(input from_run);
        begin
            i_src_flag = 7'b1010010;
            i_src_enable = 8'h24;
            if (from_run) begin
                repeat (3) begin
                    tick;
                    chk("we", 0, o_mem_we);
                end
                instr(0, 0);
            end
            for (i = 0; i < 20 && o_mem_we !== 1'b1; i = i + 1) tick;
            for (i = 0; i < 5; i = i + 1) begin
                chk("we", 1, o_mem_we);
                chk("push", ctx[8*i+:8], o_mem_wdata);
                tick;
            end
            chk("mask", 1, o_global_mask);
            chk("vec_hi", 16'hfff4, o_mem_addr);
            tick;
            chk("vec_lo", 16'hfff5, o_mem_addr);
            tick;
            tick;
            chk("pc_load", 1, o_pc_load);
            chk("pc", 16'hc8c9, o_pc_value);
            chk("mode", `CMIE_MODE_RUN, o_mode);
            i_src_flag = 7'h00;
            $display("interrupt entry test ended");
        end
    endtask
    task t_ext;
        begin
            i_irq_edge_level_select = 1;
            i_irq_pin_n = 0;
            repeat (6) tick;
            chk("ext_flag", 1, o_ext_irq_flag);
            i_ext_irq_clear = 1;
            tick;
            i_ext_irq_clear = 0;
            tick;
            chk("ext_flag", 1, o_ext_irq_flag);
            i_irq_pin_n = 1;
            repeat (4) tick;
            i_ext_irq_clear = 1;
            tick;
            i_ext_irq_clear = 0;
            tick;
            chk("ext_flag", 0, o_ext_irq_flag);
            $display("external pin test ended");
        end
    endtask
    task t_stop;
        begin
            i_stop_enable_option = 1;
            i_stop_deep_select = 1;
            instr(0, 1);
            chk("mode", `CMIE_MODE_STOP, o_mode);
            chk("sys_clk", 0, o_sys_clk_en);
            chk("deep", 1, o_stop_deep);
            cmd(`CMIE_CMD_MEM_STAT, `CMIE_STAT_LOWPWR);
            cmd(`CMIE_CMD_HALT_REQ, `CMIE_STAT_OK);
            cmd(`CMIE_CMD_RESUME, `CMIE_STAT_REFUSED);
            chk("mode", `CMIE_MODE_STOP, o_mode);
            $display("stop test ended");
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {i_core_clk, i_rst, i_instr_done, i_wait_exec, i_stop_exec} = 5'h02;
        {i_stop_enable_option, i_stop_deep_select, i_ext_irq_clear} = 3'h0;
        {i_irq_pin_n, i_irq_edge_level_select} = 2'h2;
        {i_src_flag, i_src_enable, i_mem_rdata} = 23'h0;
        {i_condition_code_reg, i_accum, i_index_reg} = 24'hc3a596;
        {i_pc_high_byte, i_pc_low_byte} = 16'h8157;
        {fail_count, compares, cyc} = 0;
        repeat (5) @(posedge i_core_clk);
        tick;
        i_rst = 0;
        t_debug;
        t_wait_halt;
        t_irq(1);
        instr(1, 0);
        t_irq(0);
        t_ext;
        t_stop;
        final_report;
    end
endmodule
